// *** dv/adc_analog_model.sv ***
`timescale 1ns/1ps

// ====================================================================
// Comparator model of the analog front end
// Each input carries a fixed level. The pairing is reduced to the
// positive input, which is enough to tell channels apart but does not
// model a differential difference voltage.
module adc_analog_model
    import adc_seq_pkg::*;
#(
    parameter logic [11:0] LEVEL0 = 12'h5A3,
    parameter logic [11:0] LEVEL1 = 12'h0FF,
    parameter logic [11:0] LEVEL2 = 12'hA5C,
    parameter logic [11:0] LEVEL3 = 12'h3C0
)
(
    input  wire mux_sel_type  muxSel,
    input  wire logic [11:0]  dacCode,
    output logic              compAbove
);
    logic [11:0] level;

    always_comb begin
        case (muxSel.posSel)
            2'h0:    level = LEVEL0;
            2'h1:    level = LEVEL1;
            2'h2:    level = LEVEL2;
            default: level = LEVEL3;
        endcase
        compAbove = (level >= dacCode);
    end
endmodule : adc_analog_model

// *** dv/test_adc_channel_sequencer.sv ***
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module test_adc_channel_sequencer
    import adc_seq_pkg::*;
;
    localparam logic [11:0] LV [4] = '{12'h5A3, 12'h0FF, 12'hA5C, 12'h3C0};

    logic        ref_clk = 1'h0;
    logic        rst = 1'h1;
    logic        ctrlWrite = 1'h0;
    logic [11:0] ctrlWord = 12'h000;
    logic        conv_start_n = 1'h1;
    logic        conv_clk_in = 1'h1;
    logic        compAbove;
    mux_sel_type muxSel;
    logic        inputsHeld, resultValid, convAbort, busy;
    logic [11:0] dacCode, resultCode;
    logic [1:0]  convChannel;
    logic        rangeDouble, refInternal, analogPowered, refPowered;
    logic        reprogramHazard;
    int          failures = 0, n_tests = 0, cycles = 0;
    int          nValid = 0, nAbort = 0, nHazard = 0, v0, a0;

    always #2.5 ref_clk = ~ref_clk;

    adc_channel_sequencer i_dut (.ref_clk(ref_clk), .rst(rst),
        .ctrlWrite(ctrlWrite), .ctrlWord(ctrlWord),
        .conv_start_n(conv_start_n), .conv_clk_in(conv_clk_in),
        .compAbove(compAbove), .muxSel(muxSel), .inputsHeld(inputsHeld),
        .dacCode(dacCode), .resultCode(resultCode),
        .resultValid(resultValid), .convAbort(convAbort), .busy(busy),
        .convChannel(convChannel), .rangeDouble(rangeDouble),
        .refInternal(refInternal), .analogPowered(analogPowered),
        .refPowered(refPowered), .reprogramHazard(reprogramHazard));

    adc_analog_model #(.LEVEL0(LV[0]), .LEVEL1(LV[1]), .LEVEL2(LV[2]),
        .LEVEL3(LV[3])) i_model (.muxSel(muxSel), .dacCode(dacCode),
        .compAbove(compAbove));

    // ================================================================
    // Tasks
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    function automatic logic [11:0] mk(input logic [1:0] pwr, addr, typ,
                                       seq, input logic cod, rng);
        logic [11:0] w;
        w = 12'h000;
        w[`CTRL_CODING_BIT] = cod;
        w[`CTRL_PWR_HI_BIT:`CTRL_PWR_LO_BIT] = pwr;
        w[`CTRL_REF_BIT] = cod;
        w[`CTRL_ADDR_HI:`CTRL_ADDR_LO] = addr;
        w[`CTRL_TYPE_HI:`CTRL_TYPE_LO] = typ;
        w[`CTRL_SEQ_HI_BIT:`CTRL_SEQ_LO_BIT] = seq;
        w[`CTRL_RANGE_BIT] = rng;
        return w;
    endfunction : mk

    task automatic write_ctrl(input logic [11:0] w);
        @(posedge ref_clk);
        ctrlWrite <= 1'h1;
        ctrlWord  <= w;
        @(posedge ref_clk);
        ctrlWrite <= 1'h0;
        repeat (3) @(posedge ref_clk);
    endtask : write_ctrl

    // The start pin is held low long enough to pass the synchroniser.
    task automatic start_conv();
        @(posedge ref_clk);
        conv_start_n <= 1'h0;
        repeat (6) @(posedge ref_clk);
        conv_start_n <= 1'h1;
        repeat (4) @(posedge ref_clk);
    endtask : start_conv

    task automatic clock_falls(input int n);
        repeat (n) begin
            conv_clk_in <= 1'h0;
            repeat (4) @(posedge ref_clk);
            conv_clk_in <= 1'h1;
            repeat (4) @(posedge ref_clk);
        end
        repeat (8) @(posedge ref_clk);
    endtask : clock_falls

    task automatic convert_check(input logic [1:0] ch, input logic cod);
        v0 = nValid;
        start_conv();
        check(12'(convChannel), 12'(ch));
        check(12'(muxSel.posSel), 12'(ch));
        check(12'(inputsHeld), 12'h001);
        clock_falls(13);
        check(12'(nValid - v0), 12'h001);
        check(resultCode, LV[ch] ^ {cod, 11'h000});
        check(12'(inputsHeld), 12'h000);
    endtask : convert_check

    // ================================================================
    // Monitors and hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (resultValid === 1'h1) nValid++;
        if (convAbort === 1'h1) nAbort++;
        if (reprogramHazard === 1'h1) nHazard++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    // ================================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'h0;
        repeat (3) @(posedge ref_clk);
        check({analogPowered, refPowered}, 12'h003);
        for (int c = 0; c < 4; c++) begin
            write_ctrl(mk(2'h0, 2'(c), 2'h0, 2'h0, 1'h0, 1'h0));
            convert_check(2'(c), 1'h0);
        end
        // Reserved encodings must behave as sequencing off.
        write_ctrl(mk(2'h0, 2'h1, 2'h0, 2'h1, 1'h0, 1'h0));
        convert_check(2'h1, 1'h0);
        convert_check(2'h1, 1'h0);
        write_ctrl(mk(2'h0, 2'h3, 2'h0, 2'h2, 1'h0, 1'h0));
        convert_check(2'h3, 1'h0);
        write_ctrl(mk(2'h0, 2'h2, 2'h0, 2'h3, 1'h0, 1'h0));
        for (int i = 0; i < 4; i++) begin
            convert_check(2'(i % 3), 1'h0);
        end
        write_ctrl(mk(2'h0, 2'h3, 2'h1, 2'h3, 1'h0, 1'h0));
        for (int i = 0; i < 3; i++) begin
            convert_check(2'(i % 2 * 2), 1'h0);
        end
        check(12'(muxSel), 12'h002);
        write_ctrl(mk(2'h0, 2'h2, 2'h2, 2'h3, 1'h0, 1'h0));
        for (int i = 0; i < 3; i++) begin
            convert_check(2'(i % 2 * 2), 1'h0);
        end
        write_ctrl(mk(2'h0, 2'h3, 2'h0, 2'h0, 1'h1, 1'h1));
        check({rangeDouble, refInternal}, 12'h003);
        convert_check(2'h3, 1'h1);
        // A short conversion followed by a new start is abandoned.
        write_ctrl(mk(2'h0, 2'h2, 2'h0, 2'h0, 1'h0, 1'h0));
        v0 = nValid;
        a0 = nAbort;
        start_conv();
        clock_falls(12);
        check(12'(nValid - v0), 12'h000);
        check(12'(busy), 12'h001);
        convert_check(2'h2, 1'h0);
        check(12'(nAbort - a0), 12'h001);
        check(12'(nHazard > 0), 12'h001);
        check(12'(reprogramHazard), 12'h000);
        // A late abort whose hazard is cleared by a clock fall instead.
        start_conv();
        clock_falls(12);
        conv_start_n <= 1'h0;
        repeat (4) @(posedge ref_clk);
        check(12'(reprogramHazard), 12'h001);
        conv_clk_in <= 1'h0;
        repeat (4) @(posedge ref_clk);
        check(12'(reprogramHazard), 12'h000);
        conv_start_n <= 1'h1;
        conv_clk_in  <= 1'h1;
        repeat (4) @(posedge ref_clk);
        write_ctrl(mk(2'h1, 2'h1, 2'h0, 2'h0, 1'h0, 1'h0));
        convert_check(2'h1, 1'h0);
        check({analogPowered, refPowered}, 12'h000);
        write_ctrl(mk(2'h2, 2'h1, 2'h0, 2'h0, 1'h0, 1'h0));
        convert_check(2'h1, 1'h0);
        check({analogPowered, refPowered}, 12'h001);
        write_ctrl(mk(2'h3, 2'h1, 2'h0, 2'h0, 1'h0, 1'h1));
        check({analogPowered, refPowered}, 12'h000);
        check({rangeDouble, refInternal}, 12'h002);
        write_ctrl(mk(2'h0, 2'h0, 2'h0, 2'h0, 1'h0, 1'h0));
        check({analogPowered, refPowered}, 12'h003);
        complete_run();
    end
endmodule : test_adc_channel_sequencer

// *** logic/adc_channel_sequencer.sv ***
// Overview of operation
// - A conversion needs thirteen complete conversion clock periods.
// - With fewer than thirteen periods a new start abandons the conversion.
// - Sequencer bits both zero: convert the last written channel.
// - Sequencer bits both one: cycle channel 0 up to final channel.
// - Differential pairings skip the swapped-polarity channel codes.
// - Sequencer advances on each falling edge of conversion start while sequencing is on.
// - Inputs form four single, two differential or two pseudo pairs.
// - Range bit picks zero to reference or zero to twice reference.
// - Coding bit picks straight binary or twos complement result.
// - Two power bits of the control word choose the power mode.
// - Inputs are disconnected and held from conversion start to result.
// - Conversion ends on the thirteenth clock fall, then codes out.
// - Address bits pick next channel, or final channel when sequencing.
// - Two input-type bits select the analog pairing.
// - Auto shutdown powers everything down after each conversion.
// - Full shutdown keeps the control register contents.
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module adc_channel_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    ctrlWrite,
    input  wire logic [`CTRL_WIDTH-1:0]  ctrlWord,
    input  wire logic                    conv_start_n,
    input  wire logic                    conv_clk_in,
    input  wire logic                    compAbove,
    output mux_sel_type                  muxSel,
    output logic                         inputsHeld,
    output logic [`SAR_BITS-1:0]         dacCode,
    output logic [`SAR_BITS-1:0]         resultCode,
    output logic                         resultValid,
    output logic                         convAbort,
    output logic                         busy,
    output logic [1:0]                   convChannel,
    output logic                         rangeDouble,
    output logic                         refInternal,
    output logic                         analogPowered,
    output logic                         refPowered,
    output logic                         reprogramHazard
);

    // ================================================================
    // Pin synchronisers
    logic startLevel;
    logic startRise;
    logic startFall;
    logic clkLevel;
    logic clkRise;
    logic clkFall;
    logic compLevel;

    pin_sync startSync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pinIn   (conv_start_n),
        .level   (startLevel),
        .rise    (startRise),
        .fall    (startFall)
    );

    pin_sync clkSync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pinIn   (conv_clk_in),
        .level   (clkLevel),
        .rise    (clkRise),
        .fall    (clkFall)
    );

    pin_sync compSync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pinIn   (compAbove),
        .level   (compLevel),
        .rise    (),
        .fall    ()
    );

    // ================================================================
    // Control register
    ctrl_type ctrl;
    localparam logic [`CTRL_WIDTH-1:0] CTRL_RESET_WORD = `CTRL_RESET;

    // A power mode never touches this register, so a full shutdown keeps
    // the whole configuration.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl <= ctrl_type'({CTRL_RESET_WORD[11:8],
                                CTRL_RESET_WORD[6:0]});
        end else if (ctrlWrite) begin
            ctrl.coding      <= ctrlWord[`CTRL_CODING_BIT];
            ctrl.pwrSel      <= pwr_mode_type'({ctrlWord[`CTRL_PWR_HI_BIT],
                                ctrlWord[`CTRL_PWR_LO_BIT]});
            ctrl.refInternal <= ctrlWord[`CTRL_REF_BIT];
            ctrl.chanAddr    <= ctrlWord[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
            ctrl.inputType   <= ctrlWord[`CTRL_TYPE_HI:`CTRL_TYPE_LO];
            ctrl.seqCtrlHi   <= ctrlWord[`CTRL_SEQ_HI_BIT];
            ctrl.seqCtrlLo   <= ctrlWord[`CTRL_SEQ_LO_BIT];
            ctrl.rangeDouble <= ctrlWord[`CTRL_RANGE_BIT];
        end
    end

    // ================================================================
    // Sequencer
    logic       seqOn;
    logic       pairMode;
    logic [1:0] lastChan;
    logic [2:0] stepSum;
    logic [1:0] seqPtr;
    logic [1:0] next_seqPtr;
    logic [1:0] startChan;

    // Reserved encodings fall through to sequencing off.
    assign seqOn    = ctrl.seqCtrlHi & ctrl.seqCtrlLo;
    assign pairMode = (ctrl.inputType == IN_FULL_DIFF) ||
                      (ctrl.inputType == IN_PSEUDO_DIFF);
    assign lastChan = pairMode ? {ctrl.chanAddr[1], 1'b0}
                               : ctrl.chanAddr;
    assign stepSum  = {1'b0, seqPtr} + (pairMode ? 3'h2 : 3'h1);
    assign next_seqPtr = (stepSum > {1'b0, lastChan}) ? 2'h0
                                                      : stepSum[1:0];
    assign startChan   = seqOn ? seqPtr : ctrl.chanAddr;

    // A control write restarts the list at channel 0.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seqPtr <= 2'h0;
        end else if (ctrlWrite) begin
            seqPtr <= 2'h0;
        end else if (startFall && seqOn) begin
            seqPtr <= next_seqPtr;
        end
    end

    // ================================================================
    // Conversion engine
    conv_state_type             state;
    logic [3:0]                 periodCount;
    logic [`SAR_BITS-1:0]       sarCode;
    logic [`SAR_BITS-1:0]       next_sarCode;
    logic [`SAR_BITS-1:0]       trialBit;
    logic                       lastPeriod;

    assign trialBit   = `SAR_FIRST_TRIAL >> periodCount;
    assign lastPeriod = (periodCount == (`CONV_PERIODS - 4'h1));
    assign next_sarCode = compLevel ? sarCode : (sarCode & ~trialBit);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state       <= CONV_IDLE;
            periodCount <= 4'h0;
            sarCode     <= 12'h000;
        end else if (startFall) begin
            state       <= CONV_RUN;
            periodCount <= 4'h0;
            sarCode     <= `SAR_FIRST_TRIAL;
        end else if (state == CONV_RUN && clkFall) begin
            periodCount <= periodCount + 4'h1;
            if (periodCount <= `LAST_BIT_PERIOD) begin
                sarCode <= next_sarCode | (trialBit >> 1);
            end
            if (lastPeriod) begin
                state <= CONV_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dacCode <= 12'h000;
        end else begin
            dacCode <= sarCode;
        end
    end

    // A new start before the thirteenth fall drops the old conversion.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            convAbort <= 1'b0;
        end else begin
            convAbort <= startFall && state == CONV_RUN;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            resultValid <= 1'b0;
            resultCode  <= 12'h000;
        end else begin
            resultValid <= 1'b0;
            if (!startFall && state == CONV_RUN && clkFall && lastPeriod) begin
                resultValid <= 1'b1;
                resultCode  <= {sarCode[`SAR_BITS-1] ^ ctrl.coding,
                                sarCode[`SAR_BITS-2:0]};
            end
        end
    end

    // The host may only reprogram after a late abort once the sequencer has
    // seen a start rise or a clock fall; this flag shows the unsafe window.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reprogramHazard <= 1'b0;
        end else if (startFall && state == CONV_RUN && lastPeriod &&
                     clkLevel) begin
            reprogramHazard <= 1'b1;
        end else if (startRise || clkFall) begin
            reprogramHazard <= 1'b0;
        end
    end

    // ================================================================
    // Input switching and hold
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            convChannel <= 2'h0;
            muxSel      <= '0;
        end else if (startFall) begin
            convChannel        <= startChan;
            muxSel.posSel      <= startChan;
            muxSel.negSel      <= startChan ^ 2'h1;
            muxSel.negToGround <= !pairMode;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inputsHeld <= 1'b0;
            busy       <= 1'b0;
        end else begin
            inputsHeld <= (state == CONV_RUN) || startFall;
            busy       <= (state == CONV_RUN) || startFall;
        end
    end

    // ================================================================
    // Range, reference and power
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rangeDouble <= 1'b0;
            refInternal <= 1'b0;
        end else begin
            rangeDouble <= ctrl.rangeDouble;
            refInternal <= ctrl.refInternal;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            analogPowered <= 1'b1;
            refPowered    <= 1'b1;
        end else begin
            unique case (ctrl.pwrSel)
                PWR_NORMAL: begin
                    analogPowered <= 1'b1;
                    refPowered    <= 1'b1;
                end
                PWR_AUTO_SHUTDOWN: begin
                    analogPowered <= (state == CONV_RUN);
                    refPowered    <= (state == CONV_RUN);
                end
                PWR_AUTO_STANDBY: begin
                    analogPowered <= (state == CONV_RUN);
                    refPowered    <= 1'b1;
                end
                PWR_FULL_SHUTDOWN: begin
                    analogPowered <= 1'b0;
                    refPowered    <= 1'b0;
                end
            endcase
        end
    end

    // ================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    thirteen_falls_a: assert property (
        resultValid |-> $past(periodCount) == 4'hC && $past(clkFall))
        else $error("Result without thirteen clock periods.");

    short_abort_a: assert property (
        (startFall && state == CONV_RUN) |=> convAbort && !resultValid)
        else $error("Short conversion was not abandoned.");

    hazard_clear_a: assert property (
        (reprogramHazard && clkFall && !startFall) |=> !reprogramHazard)
        else $error("Hazard flag did not clear on clock fall.");

    single_chan_a: assert property (
        (startFall && !seqOn) |=> convChannel == $past(ctrl.chanAddr))
        else $error("Single mode used the wrong channel.");

    seq_restart_a: assert property (
        ctrlWrite |=> seqPtr == 2'h0)
        else $error("Sequence did not start at channel 0.");

    pair_skip_a: assert property (
        (startFall && seqOn && pairMode) |=> !convChannel[0])
        else $error("Swapped pair was converted.");

    seq_step_a: assert property (
        (startFall && seqOn && !ctrlWrite) |=> seqPtr == $past(next_seqPtr))
        else $error("Sequencer did not advance.");

    hold_span_a: assert property (
        (state == CONV_RUN) |=> inputsHeld)
        else $error("Inputs released during conversion.");

    auto_off_a: assert property (
        (resultValid && ctrl.pwrSel == PWR_AUTO_SHUTDOWN && !startFall
         && !ctrlWrite) |=> !analogPowered)
        else $error("Auto shutdown left circuitry powered.");

    coding_a: assert property (
        resultValid |-> resultCode[11] == ($past(sarCode[11]) ^
                                           $past(ctrl.coding)))
        else $error("Result coding is wrong.");

    keep_ctrl_a: assert property (
        (!ctrlWrite && ctrl.pwrSel == PWR_FULL_SHUTDOWN) |=> $stable(ctrl))
        else $error("Control register changed without a write.");

    done_cover: cover property (resultValid);
    abort_cover: cover property (convAbort);
    seq_wrap_cover: cover property (startFall && seqOn && seqPtr != 2'h0
                                    ##1 seqPtr == 2'h0);
    hazard_cover: cover property (reprogramHazard);

endmodule : adc_channel_sequencer

// *** logic/adc_seq_map.svh ***
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ====================================================================
// Control word field positions
`define CTRL_WIDTH      12
`define CTRL_CODING_BIT 11
`define CTRL_PWR_HI_BIT 10
`define CTRL_PWR_LO_BIT 9
`define CTRL_REF_BIT    8
`define CTRL_ADDR_HI    6
`define CTRL_ADDR_LO    5
`define CTRL_TYPE_HI    4
`define CTRL_TYPE_LO    3
`define CTRL_SEQ_HI_BIT 2
`define CTRL_SEQ_LO_BIT 1
`define CTRL_RANGE_BIT  0

// ====================================================================
// Reset values and conversion timing
`define CTRL_RESET      12'h000
`define SAR_BITS        12
`define SAR_FIRST_TRIAL 12'h800
`define CONV_PERIODS    4'hD
`define LAST_BIT_PERIOD 4'hB

`endif

// *** logic/adc_seq_pkg.sv ***
package adc_seq_pkg;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_AUTO_SHUTDOWN,
        PWR_AUTO_STANDBY,
        PWR_FULL_SHUTDOWN
    } pwr_mode_type;

    typedef enum logic [1:0] {
        IN_SINGLE,
        IN_FULL_DIFF,
        IN_PSEUDO_DIFF,
        IN_UNUSED
    } input_type_type;

    typedef enum logic {
        CONV_IDLE,
        CONV_RUN
    } conv_state_type;

    typedef struct packed {
        logic         coding;
        pwr_mode_type pwrSel;
        logic         refInternal;
        logic [1:0]   chanAddr;
        logic [1:0]   inputType;
        logic         seqCtrlHi;
        logic         seqCtrlLo;
        logic         rangeDouble;
    } ctrl_type;

    typedef struct packed {
        logic [1:0] posSel;
        logic [1:0] negSel;
        logic       negToGround;
    } mux_sel_type;

endpackage : adc_seq_pkg

// *** logic/pin_sync.sv ***
`timescale 1ns/1ps

module pin_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    // ================================================================
    // Two-stage synchroniser; only the second stage feeds the edges.
    logic stage1;
    logic stage2;
    logic prev;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            prev   <= 1'b0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            prev   <= stage2;
        end
    end

    assign level = stage2;
    assign rise  = stage2 & ~prev;
    assign fall  = ~stage2 & prev;

endmodule : pin_sync
